/* File: rtl/bcc_defs.vh */
// Constants for the battery charge control state machine
`ifndef BCC_DEFS_VH
`define BCC_DEFS_VH

// Clock period in ns (20 MHz)
`define BCC_CLK_NS          32'h0000_0032
// Initialization time of the timer block, in ns, and cycles (ns / 50)
`define BCC_INIT_NS         32'h000F_4240
`define BCC_INIT_CYC        64'h0000_0000_0000_4E20
// Nominal top-off and precharge limit in seconds, and cycles at 20 MHz;
// written out at 64 bits, as the product overflows 32-bit arithmetic
`define BCC_HOUR_S          32'h0000_0E10
`define BCC_HOUR_CYC        64'h0000_0010_C388_D000
// Hold-off is time-out divided by 2^5
`define BCC_HOLDOFF_SHIFT   6'h05
// Trickle pulse: on and period in cycles
`define BCC_TRK_ON_CYC      16'h0100
`define BCC_TRK_PER_CYC     16'h1000
// Time-out default in cycles
`define BCC_TIMEOUT_CYC     64'h0000_0000_4000_0000

// State codes
`define BCC_ST_INIT         4'h0
`define BCC_ST_PRECHG       4'h1
`define BCC_ST_FAST         4'h2
`define BCC_ST_TOPOFF       4'h3
`define BCC_ST_FILLUP       4'h4
`define BCC_ST_STBY_VREG    4'h5
`define BCC_ST_STBY_TRK     4'h6
`define BCC_ST_STBY_OFF     4'h7
`define BCC_ST_REFRESH      4'h8
`define BCC_ST_CUTOFF       4'h9
`define BCC_ST_INHIBIT      4'hA
`define BCC_ST_STOP         4'hB

// Regulation select codes
`define BCC_REG_OFF         3'h0
`define BCC_REG_FAST        3'h1
`define BCC_REG_TOPOFF      3'h2
`define BCC_REG_PRECHG      3'h3
`define BCC_REG_VOLT        3'h4
`define BCC_REG_TRICKLE     3'h5

`endif

/* File: rtl/bcc_sync.v */
// Two-flop synchroniser bank for comparator flags
`timescale 1ns/1ps
module bcc_sync #(
    parameter W = 8
) (
    input  wire         clk,   // Clock
    input  wire         nrst,  // Synchronous reset, active low
    input  wire [W-1:0] d,     // Asynchronous flags
    output reg  [W-1:0] q      // Synchronised flags
);
    reg [W-1:0] meta_r;

    // -------------------------------------------------
    // Synchroniser; first stage feeds only the second
    // -------------------------------------------------
    always @(posedge clk)
    begin
        if (!nrst)
        begin
            meta_r <= {W{1'b0}};
            q      <= {W{1'b0}};
        end
        else
        begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule // bcc_sync

/* File: rtl/bcc_timer.v */
// Pausable up-counter with programmable limit
`timescale 1ns/1ps
module bcc_timer (
    input  wire        clk,    // Clock
    input  wire        nrst,   // Synchronous reset, active low
    input  wire        clr,    // Restart count at zero
    input  wire        run,    // Count this cycle, else hold
    input  wire [63:0] limit,  // Expiry count
    output reg  [63:0] count,  // Current count
    output reg         done    // Count reached limit
);
    // -------------------------------------------------
    // Counter; holds when not running so pauses resume
    // -------------------------------------------------
    always @(posedge clk)
    begin
        if (!nrst || clr)
        begin
            count <= 64'h0;
            done  <= 1'b0;
        end
        else if (run && !done)
        begin
            count <= count + 64'h1;
            done  <= (count + 64'h1 >= limit);
        end
    end
endmodule // bcc_timer

/* File: rtl/bcc_fsm.v */
// Battery charge control state machine
`timescale 1ns/1ps
`include "bcc_defs.vh"
module bcc_fsm #(
    parameter [63:0] TIMEOUT_CYC = `BCC_TIMEOUT_CYC,  // Time-out length
    parameter [63:0] HOUR_CYC    = `BCC_HOUR_CYC,     // One hour
    parameter [63:0] INIT_CYC    = `BCC_INIT_CYC      // Initialization time
) (
    input  wire       clk,                 // 20 MHz clock
    input  wire       nrst,                // Power-on reset, active low
    input  wire       batt_insert,         // Battery insertion event level
    input  wire       id_low,              // Identification pin low (lithium/lead)
    input  wire       id_lithium,          // Identification at 0 V (else lead at 1.25 V)
    input  wire       id_high,             // Identification high (both criteria)
    input  wire       thermistor_present,  // Thermistor input in detect window
    input  wire       standby_low,         // Standby setpoint grounded (inhibit)
    input  wire       standby_ref,         // Standby setpoint tied to reference
    input  wire       refresh_low,         // Refresh request pressed
    input  wire       v_full_li,           // Cell at or above 4.1 V
    input  wire       v_full_pb,           // Cell at or above 2.45 V
    input  wire       v_below_3,           // Cell below 3 V
    input  wire       v_below_1p5,         // Cell below 1.5 V
    input  wire       v_above_0p9,         // Cell above 0.9 V
    input  wire       v_above_0p45,        // Cell above 0.45 V
    input  wire       v_end_dis,           // Cell at 1 V, discharge done
    input  wire       v_low,               // Low battery voltage
    input  wire       temp_in_window,      // Temperature inside init window
    input  wire       volt_in_window,      // Voltage inside init window
    input  wire       temp_cut,            // Temperature protection active
    input  wire       dtdt_full,           // Temperature-rate full detect
    input  wire       peak_full,           // Voltage peak detect full
    input  wire       ilim_2h,             // Current limited over two hours
    output reg  [3:0] state_out,           // Encoded state
    output reg  [2:0] reg_sel,             // Regulation select
    output reg        drive_en,            // Charge drive enable
    output reg        discharge_en,        // Refresh discharge enable
    output reg        timer_init,          // Timer block in init mode
    output reg        indicators_en,       // Program pins as indicators
    output reg        nickel,              // Latched chemistry is nickel
    output reg        peak_select,         // Voltage peak detection in use
    output reg        full_flag            // Full detected
);
    // -------------------------------------------------
    // Input synchronisation
    // -------------------------------------------------
    // All comparator and pin levels cross into the clock domain through two
    // flops; this costs two cycles of latency on every decision
    wire [22:1] raw = {batt_insert, id_low, id_lithium, id_high, thermistor_present,
                       standby_low, standby_ref, refresh_low, v_full_li, v_full_pb,
                       v_below_3, v_below_1p5, v_above_0p9, v_above_0p45, v_end_dis,
                       v_low, temp_in_window, volt_in_window, temp_cut, dtdt_full,
                       peak_full, ilim_2h};
    wire [22:1] s;

    bcc_sync #(.W(22)) u_sync (
        .clk  (clk),
        .nrst (nrst),
        .d    (raw),
        .q    (s)
    );

    wire s_ins   = s[22];
    wire s_idlo  = s[21];
    wire s_idli  = s[20];
    wire s_idhi  = s[19];
    wire s_therm = s[18];
    wire s_inh   = s[17];
    wire s_sref  = s[16];
    wire s_refresh = s[15];
    wire s_fli   = s[14];
    wire s_fpb   = s[13];
    wire s_b3    = s[12];
    wire s_b15   = s[11];
    wire s_a09   = s[10];
    wire s_a045  = s[9];
    wire s_edis  = s[8];
    wire s_vlow  = s[7];
    wire s_twin  = s[6];
    wire s_vwin  = s[5];
    wire s_tcut  = s[4];
    wire s_dtdt  = s[3];
    wire s_peak  = s[2];
    wire s_il2h  = s[1];

    // -------------------------------------------------
    // State and latched configuration
    // -------------------------------------------------
    reg  [3:0] st_r, st_nxt;
    reg        ins_d_r;
    reg        lith_r, lead_r, both_r, vreg_stby_r;
    reg  [15:0] trk_r;
    // Insertion is a rising edge of the synchronised level; ins_d_r resets low
    // like the idle pin, so a pack already fitted at power-up only restarts init
    wire       ins_edge = s_ins && !ins_d_r;
    wire       li_pb    = lith_r || lead_r;

    // Timers: time-out pauses on low voltage, temperature and inhibit
    wire        to_run  = !s_vlow && !s_tcut && !s_inh;
    wire        sess_clr = (st_r != st_nxt) && (st_nxt == `BCC_ST_FAST ||
                           st_nxt == `BCC_ST_FILLUP || st_nxt == `BCC_ST_PRECHG);
    wire [63:0] to_cnt, hr_cnt, in_cnt;
    wire        to_done, hr_done, in_done;
    wire        hold_off = (to_cnt < (TIMEOUT_CYC >> `BCC_HOLDOFF_SHIFT));

    // Session timer: time-out, and hold-off as its first 1/32; cleared on entry
    // to precharge, fast charge and fill-up, so each session has a fresh hold-off
    bcc_timer u_to (
        .clk   (clk),
        .nrst  (nrst),
        .clr   (sess_clr),
        .run   (to_run),
        .limit (TIMEOUT_CYC),
        .count (to_cnt),
        .done  (to_done)
    );

    // Hour timer serves top-off and precharge; frozen by inhibit
    bcc_timer u_hr (
        .clk   (clk),
        .nrst  (nrst),
        .clr   ((st_r != st_nxt)),
        .run   (!s_inh),
        .limit (HOUR_CYC),
        .count (hr_cnt),
        .done  (hr_done)
    );

    // Initialization timer; an insertion edge restarts it from zero. Inhibit
    // stops it, so a pack inserted while inhibited waits before choosing a method
    bcc_timer u_init (
        .clk   (clk),
        .nrst  (nrst),
        .clr   (ins_edge),
        .run   (st_r == `BCC_ST_INIT && !s_inh),
        .limit (INIT_CYC),
        .count (in_cnt),
        .done  (in_done)
    );

    // -------------------------------------------------
    // Full detection with thermistor fallback
    // -------------------------------------------------
    // Rate detection needs a thermistor; without one, voltage peak takes over so
    // a pack without a sensor is still terminated. Peak is also used when the
    // chemistry select asks for both criteria.
    wire use_peak = !s_therm || both_r || s_idhi;
    wire use_dtdt = s_therm;
    wire ni_full  = (use_dtdt && s_dtdt) || (use_peak && s_peak);
    // Full results are simply discarded during hold-off, not stored for later
    wire full_ok  = !hold_off;

    // -------------------------------------------------
    // Next-state logic
    // -------------------------------------------------
    always @*
    begin
        st_nxt = st_r;
        case (st_r)
            // Method is chosen once the init time has passed and chemistry is latched
            `BCC_ST_INIT:
                if (in_done)
                    st_nxt = li_pb && !(lith_r ? s_a09 : s_a045) ?
                             `BCC_ST_PRECHG : `BCC_ST_FAST;
            `BCC_ST_PRECHG:
                if (lith_r ? s_a09 : s_a045)
                    st_nxt = `BCC_ST_FAST;
                else if (hr_done)
                    st_nxt = `BCC_ST_CUTOFF;
            // Refresh wins over every end of fast charge; it is refused for lithium/lead
            `BCC_ST_FAST:
                if (!li_pb && s_refresh)
                    st_nxt = `BCC_ST_REFRESH;
                else if (s_tcut || to_done)
                    st_nxt = li_pb ? `BCC_ST_STBY_OFF : `BCC_ST_TOPOFF;
                else if (li_pb && full_ok && (lith_r ? s_fli : s_fpb))
                    st_nxt = `BCC_ST_FILLUP;
                else if (!li_pb && full_ok && ni_full)
                    st_nxt = `BCC_ST_TOPOFF;
            // A low cell voltage ends top-off early so a bench test need not wait
            `BCC_ST_TOPOFF:
                if (!s_refresh && (hr_done || s_vlow))
                    st_nxt = vreg_stby_r ? `BCC_ST_STBY_VREG : `BCC_ST_STBY_TRK;
                else if (s_refresh)
                    st_nxt = `BCC_ST_REFRESH;
            `BCC_ST_FILLUP:
                if (to_done || s_vlow)
                    st_nxt = `BCC_ST_STBY_OFF;
            // Lithium/lead standby has no drive; a falling cell restarts fast charge
            `BCC_ST_STBY_OFF:
                if (lith_r ? s_b3 : s_b15)
                    st_nxt = `BCC_ST_FAST;
            // Current held at its limit too long, or over-temperature, stops until a new insertion
            `BCC_ST_STBY_VREG:
                if (s_tcut || s_il2h)
                    st_nxt = `BCC_ST_STOP;
                else if (s_refresh)
                    st_nxt = `BCC_ST_REFRESH;
            `BCC_ST_STBY_TRK:
                if (s_refresh)
                    st_nxt = `BCC_ST_REFRESH;
            `BCC_ST_REFRESH:
                if (s_edis)
                    st_nxt = `BCC_ST_FAST;
            `BCC_ST_CUTOFF:
                st_nxt = `BCC_ST_CUTOFF;
            `BCC_ST_STOP:
                st_nxt = `BCC_ST_STOP;
            default:
                st_nxt = `BCC_ST_INIT;
        endcase
        // Inhibit freezes the state; insertion restarts except after cut-off
        if (s_inh)
            st_nxt = st_r;
        else if (ins_edge && st_r != `BCC_ST_CUTOFF)
            st_nxt = `BCC_ST_INIT;
    end

    // -------------------------------------------------
    // State, chemistry latch and trickle pulse counter
    // -------------------------------------------------
    always @(posedge clk)
    begin
        if (!nrst)
        begin
            st_r        <= `BCC_ST_INIT;
            ins_d_r     <= 1'b0;
            lith_r      <= 1'b0;
            lead_r      <= 1'b0;
            both_r      <= 1'b0;
            vreg_stby_r <= 1'b0;
            trk_r       <= 16'h0000;
        end
        else
        begin
            st_r    <= st_nxt;
            ins_d_r <= s_ins;
            // Latch chemistry and standby method while initializing
            if (st_r == `BCC_ST_INIT && !in_done)
            begin
                lith_r      <= s_idlo && s_idli;
                lead_r      <= s_idlo && !s_idli;
                both_r      <= s_idhi;
                vreg_stby_r <= !s_sref && s_therm;
            end
            // Trickle phase counter; inhibit holds it, like every other timer
            if (st_r == `BCC_ST_STBY_TRK && !s_inh)
                trk_r <= (trk_r >= `BCC_TRK_PER_CYC - 16'h1) ? 16'h0000 : trk_r + 16'h1;
            else if (!s_inh)
                trk_r <= 16'h0000;
        end
    end

    // -------------------------------------------------
    // Registered outputs
    // -------------------------------------------------
    reg [2:0] sel_nxt;
    reg       drv_nxt;

    // Output drive per state; inhibit and cut-off force zero
    always @*
    begin
        sel_nxt = `BCC_REG_OFF;
        drv_nxt = 1'b0;
        case (st_r)
            `BCC_ST_PRECHG:    begin sel_nxt = `BCC_REG_PRECHG; drv_nxt = 1'b1; end
            `BCC_ST_FAST:
                begin
                    drv_nxt = 1'b1;
                    sel_nxt = (!li_pb && !(s_twin && s_vwin)) ?
                              `BCC_REG_TOPOFF : `BCC_REG_FAST;
                end
            `BCC_ST_TOPOFF:    begin sel_nxt = `BCC_REG_TOPOFF; drv_nxt = 1'b1; end
            `BCC_ST_FILLUP:    begin sel_nxt = `BCC_REG_VOLT;   drv_nxt = 1'b1; end
            `BCC_ST_STBY_VREG: begin sel_nxt = `BCC_REG_VOLT;   drv_nxt = 1'b1; end
            `BCC_ST_STBY_TRK:
                begin
                    sel_nxt = `BCC_REG_TRICKLE;
                    drv_nxt = (trk_r < `BCC_TRK_ON_CYC);
                end
            default:           begin sel_nxt = `BCC_REG_OFF;    drv_nxt = 1'b0; end
        endcase
        if (s_inh)
        begin
            sel_nxt = `BCC_REG_OFF;
            drv_nxt = 1'b0;
        end
    end

    // Output registers; every port comes from a flop, at the cost of one more
    // cycle of latency behind the state. Inhibit is shown as its own code while
    // the underlying state stays frozen underneath it.
    always @(posedge clk)
    begin
        if (!nrst)
        begin
            state_out     <= `BCC_ST_INIT;
            reg_sel       <= `BCC_REG_OFF;
            drive_en      <= 1'b0;
            discharge_en  <= 1'b0;
            timer_init    <= 1'b1;
            indicators_en <= 1'b0;
            nickel        <= 1'b1;
            peak_select   <= 1'b0;
            full_flag     <= 1'b0;
        end
        else
        begin
            state_out     <= s_inh ? `BCC_ST_INHIBIT : st_r;
            reg_sel       <= sel_nxt;
            drive_en      <= drv_nxt;
            discharge_en  <= (st_r == `BCC_ST_REFRESH) && !s_inh;
            timer_init    <= (st_r == `BCC_ST_INIT);
            indicators_en <= (st_r != `BCC_ST_INIT) && !s_inh;
            nickel        <= !li_pb;
            peak_select   <= use_peak;
            full_flag     <= (st_r == `BCC_ST_TOPOFF || st_r == `BCC_ST_FILLUP ||
                              st_r == `BCC_ST_STBY_VREG || st_r == `BCC_ST_STBY_TRK ||
                              st_r == `BCC_ST_STBY_OFF);
        end
    end
endmodule // bcc_fsm

/* File: tb/bcc_fsm_asserts.sv */
// Concurrent checks on the charge control state machine ports
`timescale 1ns/1ps
`include "bcc_defs.vh"
module bcc_fsm_asserts (
    input logic       clk,           // Clock
    input logic       nrst,          // Sync reset, active low
    input logic       standby_low,   // Inhibit request
    input logic [3:0] state_out,     // Encoded state
    input logic [2:0] reg_sel,       // Regulation select
    input logic       drive_en,      // Charge drive
    input logic       timer_init,    // Timer init mode
    input logic       indicators_en  // Indicator pins live
);
    // --------------------
    // Settled state
    // --------------------
    // Outputs trail the state by an edge, so output checks wait for a repeat
    logic [3:0] prev_st_r;
    wire  [3:0] st_s = (state_out == prev_st_r) ? state_out : 4'hF;
    always @(posedge clk)
    begin
        prev_st_r <= state_out;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    // --------------------
    // Properties
    // --------------------
    AST_INHIBIT_ENTRY:
        assert property ($rose(standby_low) |-> ##[1:6] state_out == `BCC_ST_INHIBIT) else $error("no inhibit");
    AST_INHIBIT_OUT:
        assert property (st_s == `BCC_ST_INHIBIT |-> !drive_en && !indicators_en) else $error("inhibit output on");
    AST_CUTOFF_HOLD:
        assert property (state_out == `BCC_ST_CUTOFF |=> state_out == `BCC_ST_CUTOFF) else $error("cut-off left");
    AST_CUTOFF_DRIVE:
        assert property (st_s == `BCC_ST_CUTOFF |-> !drive_en && reg_sel == `BCC_REG_OFF) else $error("cut-off drive");
    AST_FILLUP_VOLT:
        assert property (st_s == `BCC_ST_FILLUP |-> drive_en && reg_sel == `BCC_REG_VOLT) else $error("fill-up select");
    AST_STBYOFF_ZERO:
        assert property (st_s == `BCC_ST_STBY_OFF |-> !drive_en && reg_sel == `BCC_REG_OFF) else $error("standby drive");
    AST_PRECHG_SEL:
        assert property (st_s == `BCC_ST_PRECHG |-> drive_en && reg_sel == `BCC_REG_PRECHG) else $error("precharge sel");
    AST_INIT_INDIC:
        assert property (timer_init |-> !indicators_en) else $error("indicators during init");
    AST_TRICKLE_ON:
        assert property (st_s == `BCC_ST_STBY_TRK && $rose(drive_en) |->
                         (drive_en || state_out != `BCC_ST_STBY_TRK)[*8]) else $error("trickle pulse short");
endmodule // bcc_fsm_asserts

bind bcc_fsm bcc_fsm_asserts chk_u (.clk(clk), .nrst(nrst), .standby_low(standby_low), .state_out(state_out),
    .reg_sel(reg_sel), .drive_en(drive_en), .timer_init(timer_init), .indicators_en(indicators_en));

/* File: tb/bcc_pack_model.sv */
// Battery pack comparator model: cell and thermistor levels to flags
`timescale 1ns/1ps
module bcc_pack_model (
    input  wire [15:0] cell_mv,            // Cell voltage, mV
    input  wire [15:0] therm_mv,           // Thermistor pin, mV
    output wire        thermistor_present, // Thermistor fitted
    output wire        v_full_li,          // 4.1 V reached
    output wire        v_full_pb,          // 2.45 V reached
    output wire        v_below_3,          // Under 3 V
    output wire        v_below_1p5,        // Under 1.5 V
    output wire        v_above_0p9,        // Over 0.9 V
    output wire        v_above_0p45,       // Over 0.45 V
    output wire        v_end_dis,          // Discharged to 1 V
    output wire        v_low               // Under 0.3 V
);
    // --------------------
    // Comparators
    // --------------------
    // Raw levels; synchronising is the controller's job, not ours
    assign thermistor_present = therm_mv < 16'h0CE4;
    assign v_full_li          = cell_mv >= 16'h1004;
    assign v_full_pb          = cell_mv >= 16'h0992;
    assign v_below_3          = cell_mv < 16'h0BB8;
    assign v_below_1p5        = cell_mv < 16'h05DC;
    assign v_above_0p9        = cell_mv > 16'h0384;
    assign v_above_0p45       = cell_mv > 16'h01C2;
    assign v_end_dis          = cell_mv <= 16'h03E8;
    assign v_low              = cell_mv < 16'h012C;
endmodule // bcc_pack_model

/* File: tb/tb_battery_charge_control_fsm.sv */
// Self-checking bench for the battery charge control state machine
`timescale 1ns/1ps
`include "bcc_defs.vh"
module tb_battery_charge_control_fsm;
    typedef struct packed {logic li; logic lith; logic [15:0] mv; logic [3:0] st; logic [2:0] rs; logic ni;} bcc_row_t;
    logic        clk, nrst, batt_insert, id_low, id_lithium, id_high, standby_low, standby_ref, refresh_low;
    logic        temp_in_window, volt_in_window, temp_cut, dtdt_full, peak_full, ilim_2h;
    logic [15:0] cell_mv, therm_mv;
    wire         thermistor_present, v_full_li, v_full_pb, v_below_3, v_below_1p5, v_above_0p9, v_above_0p45;
    wire         v_end_dis, v_low, drive_en, discharge_en, timer_init, indicators_en, nickel, peak_select, full_flag;
    wire  [3:0]  state_out;
    wire  [2:0]  reg_sel;
    int          error_cnt, n_checks, t;
    bcc_row_t    rows [0:4];

    // Clock, 50 ns period
    always #25 clk = ~clk;

    // Shortened counts keep the run near ten thousand cycles
    bcc_fsm #(.TIMEOUT_CYC(64'h1000), .HOUR_CYC(64'h100), .INIT_CYC(64'h10)) dut_u (
        .clk(clk), .nrst(nrst), .batt_insert(batt_insert), .id_low(id_low), .id_lithium(id_lithium),
        .id_high(id_high), .thermistor_present(thermistor_present), .standby_low(standby_low),
        .standby_ref(standby_ref), .refresh_low(refresh_low), .v_full_li(v_full_li), .v_full_pb(v_full_pb),
        .v_below_3(v_below_3), .v_below_1p5(v_below_1p5), .v_above_0p9(v_above_0p9), .v_above_0p45(v_above_0p45),
        .v_end_dis(v_end_dis), .v_low(v_low), .temp_in_window(temp_in_window), .volt_in_window(volt_in_window),
        .temp_cut(temp_cut), .dtdt_full(dtdt_full), .peak_full(peak_full), .ilim_2h(ilim_2h),
        .state_out(state_out), .reg_sel(reg_sel), .drive_en(drive_en), .discharge_en(discharge_en),
        .timer_init(timer_init), .indicators_en(indicators_en), .nickel(nickel), .peak_select(peak_select),
        .full_flag(full_flag));
    bcc_pack_model pack_u (.cell_mv(cell_mv), .therm_mv(therm_mv), .thermistor_present(thermistor_present),
        .v_full_li(v_full_li), .v_full_pb(v_full_pb), .v_below_3(v_below_3), .v_below_1p5(v_below_1p5),
        .v_above_0p9(v_above_0p9), .v_above_0p45(v_above_0p45), .v_end_dis(v_end_dis), .v_low(v_low));

    // --------------------
    // Helpers
    // --------------------
    // Four-state compare, so an unknown never passes
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("ERROR %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    // Bounded wait for a state; arriving before lo cycles is a fault too
    task automatic wait_st(input logic [3:0] code, input int lo, input int hi);
        t = 0;
        while (state_out !== code && t < hi)
        begin
            @(posedge clk);
            t++;
        end
        chk("state", state_out, code);
        chk("delay", {15'h0, t >= lo}, 16'h1);
        cyc(2);
    endtask
    // Power-on reset with a new pack, then past the init time
    task automatic start(input logic li, input logic lith, input logic [15:0] mv);
        {nrst, id_low, id_lithium, cell_mv} <= {1'h0, li, lith, mv};
        cyc(3);
        nrst <= 1'h1;
        cyc(28);
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Watchdog, about three times the expected run
    initial
    begin
        repeat (30000) @(posedge clk);
        error_cnt++;
        test_done;
    end

    // --------------------
    // Tests
    // --------------------
    initial
    begin
        {clk, nrst, batt_insert, id_low, id_lithium, id_high, standby_low, standby_ref, refresh_low} = 9'h0;
        {temp_in_window, volt_in_window, temp_cut, dtdt_full, peak_full, ilim_2h} = 6'h30;
        {cell_mv, therm_mv} = {16'h04B0, 16'h0FA0};
        error_cnt = 0;
        n_checks = 0;
        rows = '{'{1'h0, 1'h0, 16'h04B0, `BCC_ST_FAST, `BCC_REG_FAST, 1'h1},
                 '{1'h1, 1'h1, 16'h01F4, `BCC_ST_PRECHG, `BCC_REG_PRECHG, 1'h0},
                 '{1'h1, 1'h1, 16'h03E8, `BCC_ST_FAST, `BCC_REG_FAST, 1'h0},
                 '{1'h1, 1'h0, 16'h0190, `BCC_ST_PRECHG, `BCC_REG_PRECHG, 1'h0},
                 '{1'h1, 1'h0, 16'h0258, `BCC_ST_FAST, `BCC_REG_FAST, 1'h0}};
        cyc(16);
        chk("reset", {state_out, reg_sel, drive_en, timer_init, indicators_en, nickel}, 16'h0005);
        $display("test reset done");
        foreach (rows[i])
        begin
            start(rows[i].li, rows[i].lith, rows[i].mv);
            chk("row state", {state_out, reg_sel}, {rows[i].st, rows[i].rs});
            chk("row chem", {nickel, timer_init, indicators_en}, {rows[i].ni, 2'h1});
        end
        $display("test table done");
        // Lithium: full during hold-off, fill-up, standby, restart, refresh and inhibit
        start(1'h1, 1'h1, 16'h03E8);
        cell_mv <= 16'h1068;
        wait_st(`BCC_ST_FILLUP, 90, 200);
        chk("fill-up", {reg_sel, full_flag}, {`BCC_REG_VOLT, 1'h1});
        wait_st(`BCC_ST_STBY_OFF, 3500, 4300);
        chk("standby drive", {reg_sel, drive_en}, 16'h0);
        cell_mv <= 16'h0B54;
        wait_st(`BCC_ST_FAST, 1, 10);
        refresh_low <= 1'h1;
        cyc(10);
        chk("refresh ignored", {state_out, discharge_en}, {`BCC_ST_FAST, 1'h0});
        {refresh_low, standby_low} <= 2'h1;
        wait_st(`BCC_ST_INHIBIT, 1, 8);
        chk("inhibit", {drive_en, indicators_en, reg_sel}, 16'h0);
        standby_low <= 1'h0;
        wait_st(`BCC_ST_FAST, 1, 10);
        $display("test lithium done");
        // Short-circuited cell: cut-off survives a new insertion
        start(1'h1, 1'h1, 16'h01F4);
        wait_st(`BCC_ST_CUTOFF, 200, 300);
        {batt_insert, cell_mv} <= {1'h1, 16'h03E8};
        cyc(4);
        batt_insert <= 1'h0;
        cyc(30);
        chk("cut-off kept", {state_out, drive_en}, {`BCC_ST_CUTOFF, 1'h0});
        $display("test cut-off done");
        // Nickel without thermistor: window, peak end, trickle, refresh
        start(1'h0, 1'h0, 16'h04B0);
        chk("peak fallback", peak_select, 16'h1);
        temp_in_window <= 1'h0;
        cyc(8);
        chk("window", {state_out, reg_sel}, {`BCC_ST_FAST, `BCC_REG_TOPOFF});
        {temp_in_window, dtdt_full} <= 2'h3;
        cyc(150);
        chk("rate ignored", state_out, `BCC_ST_FAST);
        {dtdt_full, peak_full} <= 2'h1;
        wait_st(`BCC_ST_TOPOFF, 1, 10);
        peak_full <= 1'h0;
        wait_st(`BCC_ST_STBY_TRK, 200, 300);
        t = 0;
        repeat (4096) @(posedge clk) t += int'(drive_en);
        chk("trickle on", t[15:0], 16'h0100);
        refresh_low <= 1'h1;
        wait_st(`BCC_ST_REFRESH, 1, 10);
        refresh_low <= 1'h0;
        chk("discharge", {discharge_en, drive_en}, 16'h2);
        cell_mv <= 16'h0384;
        wait_st(`BCC_ST_FAST, 1, 10);
        $display("test nickel done");
        // Nickel with thermistor: temperature cut, regulation standby, stop
        therm_mv <= 16'h07D0;
        start(1'h0, 1'h0, 16'h04B0);
        chk("peak off", peak_select, 16'h0);
        cyc(150);
        temp_cut <= 1'h1;
        wait_st(`BCC_ST_TOPOFF, 1, 10);
        temp_cut <= 1'h0;
        wait_st(`BCC_ST_STBY_VREG, 200, 300);
        chk("vreg", reg_sel, `BCC_REG_VOLT);
        ilim_2h <= 1'h1;
        wait_st(`BCC_ST_STOP, 1, 10);
        chk("stop drive", drive_en, 16'h0);
        $display("test regulation done");
        test_done;
    end
endmodule // tb_battery_charge_control_fsm
